/* File: verilog/hlt_pkg.sv */
package hlt_pkg;

  localparam int ADDR_W = 32;
  localparam int CNT_W = 32;
  localparam int NUM_STAGES = 11;
  localparam int LOOP_STACK_DEPTH = 6;
  localparam int PROD_W = 64;

  // stage slot indices, oldest last
  localparam int ST_F1 = 0;
  localparam int ST_M3 = 8;
  localparam int ST_M4 = 9;
  localparam int ST_E2 = 10;

  localparam logic [PROD_W-1:0] UNROLL_MIN = 64'h000000000000000b;
  localparam logic [CNT_W-1:0] CNT_LAST = 32'h00000001;
  localparam logic [CNT_W-1:0] CNT_STEP = 32'h00000001;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h00000001;
  localparam logic [ADDR_W-1:0] ARITH_LONG_LEN = 32'h00000003;
  localparam logic [ADDR_W-1:0] ARITH_TEST_BACK = 32'h00000002;
  localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 32'h00000000;

  typedef logic [ADDR_W-1:0] hlt_addr_t;
  typedef logic [CNT_W-1:0] hlt_cnt_t;

  typedef enum logic [1:0] {
    HLT_KIND_COUNTER,
    HLT_KIND_ARITH,
    HLT_KIND_FOREVER
  } hlt_kind_t;

  typedef enum logic {
    HLT_ST_RUN,
    HLT_ST_EXIT_WAIT
  } hlt_state_t;

  typedef struct packed {
    logic vld;
    hlt_addr_t addr;
  } hlt_slot_t;

  // loop-start descriptor, valid while the loop-start sits in the last execute stage
  typedef struct packed {
    logic vld;
    hlt_kind_t kind;
    logic late_op;
    hlt_addr_t end_addr;
    hlt_cnt_t count;
  } hlt_do_t;

  typedef struct packed {
    hlt_addr_t top_addr;
    hlt_addr_t end_addr;
    hlt_addr_t test_addr;
    hlt_kind_t kind;
    logic late;
    hlt_cnt_t count;
  } hlt_loop_t;

endpackage : hlt_pkg

/* File: verilog/hlt_pipe_track.sv */
`timescale 1ns/1ps
`default_nettype none
module hlt_pipe_track import hlt_pkg::*; #(
  parameter int STAGES = NUM_STAGES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire hlt_slot_t fetch_i,
  input wire logic [STAGES-1:0] flush_i,
  output hlt_slot_t [STAGES-1:0] stage_o
);

  typedef struct packed {
    hlt_slot_t [STAGES-1:0] stage;
  } pipe_state_t;

  pipe_state_t s_q;
  pipe_state_t s_d;

  always_comb begin
    s_d.stage[0] = fetch_i;
    for (int k = 1; k < STAGES; k++) begin
      s_d.stage[k] = s_q.stage[k-1];
      s_d.stage[k].vld = s_q.stage[k-1].vld & ~flush_i[k-1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stage_o = s_q.stage;

endmodule : hlt_pipe_track
`default_nettype wire

/* File: verilog/hlt_loop_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module hlt_loop_stack import hlt_pkg::*; #(
  parameter int DEPTH = LOOP_STACK_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire hlt_loop_t push_ent_i,
  input wire logic pop_i,
  input wire logic cnt_wr_i,
  input wire hlt_cnt_t cnt_i,
  output hlt_loop_t top_o,
  output logic empty_o,
  output logic nested_o
);

  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [PW-1:0] PTR_FULL = PW'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] ptr;
    hlt_loop_t [DEPTH-1:0] ent;
  } stk_state_t;

  stk_state_t s_q;
  stk_state_t s_d;

  always_comb begin
    logic [PW-1:0] p;
    p = s_q.ptr;
    s_d = s_q;
    if (cnt_wr_i && p != '0) begin
      s_d.ent[p - PTR_ONE].count = cnt_i;
    end
    if (pop_i && p != '0) begin
      p = p - PTR_ONE;
    end
    // a push into a full stack is dropped
    if (push_i && p != PTR_FULL) begin
      s_d.ent[p] = push_ent_i;
      p = p + PTR_ONE;
    end
    s_d.ptr = p;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign empty_o = (s_q.ptr == '0);
  assign nested_o = (s_q.ptr > PTR_ONE);
  assign top_o = empty_o ? '0 : s_q.ent[s_q.ptr - PTR_ONE];

endmodule : hlt_loop_stack
`default_nettype wire

/* File: verilog/hlt_loop_ctrl.sv */
// Operation
// RULE1: loop-start pushes end address, condition, top address and type onto stacks
// RULE2: end address in first fetch stage and loop live: fetch top next cycle
// RULE3: on true test pop both stacks, next fetch follows end address
// RULE4: late counter test only with valid end address in final stage, count one
// RULE5: late counter exit flushes fourth memory stage back to first fetch stage
// RULE6: late counter decrements in final stage, exit target fetched two cycles on
// RULE7: opcode variant picks early or late counter test
// RULE8: unrolled counter loop under eleven instructions always runs late-tested
// RULE9: force_late_loop_test_bit set makes every counter loop late-tested
// RULE10: condition loop of length three or more tests at end minus two
// RULE11: condition loop of length one or two tests at end address
// RULE12: false condition test leaves fetch and pipeline untouched
// RULE13: true condition test lets one more instruction finish, flushes younger ones
// RULE14: after condition exit fetch end instruction next, then sequential addresses
// RULE15: single-instruction condition loop is tested every cycle
// RULE16: two later instructions still run, giving extra iterations for short loops
// RULE17: nested condition true during inner call iterates outer loop once more
// RULE18: forever loop repeats with no test until interrupt or reset
// RULE19: pipeline is eleven ordered slots, flushes invalidate slots
`timescale 1ns/1ps
`default_nettype none
module hlt_loop_ctrl import hlt_pkg::*; #(
  parameter int STAGES = NUM_STAGES,
  parameter int DEPTH = LOOP_STACK_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire hlt_do_t do_i,
  input wire logic cond_true_i,
  input wire logic call_active_i,
  input wire logic force_late_loop_test_bit_i,
  output hlt_addr_t fetch_addr_o,
  output logic fetch_vld_o,
  output logic [STAGES-1:0] flush_o,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic loop_exit_o,
  output hlt_cnt_t current_loop_count_o,
  output logic loop_late_o,
  output logic loop_active_o
);

  typedef struct packed {
    hlt_state_t st;
    hlt_addr_t exit_addr;
    logic defer;
    logic [STAGES-1:0] flush;
    logic push;
    logic pop;
    logic exit_p;
    hlt_cnt_t count;
    logic late;
    logic active;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  hlt_slot_t [STAGES-1:0] stage;
  hlt_slot_t fetch_d;
  logic [STAGES-1:0] flush_d;
  logic push_d;
  logic pop_d;
  logic cnt_wr_d;
  hlt_cnt_t cnt_d;
  hlt_loop_t push_ent;
  hlt_loop_t top;
  logic empty;
  logic nested;

  // slots from the given one back to the first fetch stage
  function automatic logic [STAGES-1:0] flush_upto(input int oldest);
    logic [STAGES-1:0] m;
    m = '0;
    for (int k = 0; k < STAGES; k++) begin
      m[k] = (k <= oldest);
    end
    return m;
  endfunction : flush_upto

  // late test when opcode, short unrolled length or override say so
  function automatic logic late_select(input hlt_do_t d, input hlt_addr_t len, input logic force_late);
    logic [PROD_W-1:0] prod;
    logic short_loop;
    prod = PROD_W'(len) * PROD_W'(d.count);
    short_loop = (d.count != '0) && (prod < UNROLL_MIN); // RULE8
    return d.late_op | short_loop | force_late; // RULE7 RULE9
  endfunction : late_select

  hlt_pipe_track #(
    .STAGES(STAGES)
  ) u_pipe (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .fetch_i(fetch_d),
    .flush_i(flush_d),
    .stage_o(stage)
  );

  hlt_loop_stack #(
    .DEPTH(DEPTH)
  ) u_stack (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .push_i(push_d),
    .push_ent_i(push_ent),
    .pop_i(pop_d),
    .cnt_wr_i(cnt_wr_d),
    .cnt_i(cnt_d),
    .top_o(top),
    .empty_o(empty),
    .nested_o(nested)
  );

  // loop-start entry built from the instruction now in the final stage
  always_comb begin
    hlt_addr_t len;
    len = do_i.end_addr - stage[ST_E2].addr;
    push_ent.top_addr = stage[ST_E2].addr + ADDR_STEP;
    push_ent.end_addr = do_i.end_addr;
    push_ent.kind = do_i.kind;
    push_ent.count = do_i.count;
    push_ent.late = late_select(do_i, len, force_late_loop_test_bit_i);
    if (len >= ARITH_LONG_LEN) begin
      push_ent.test_addr = do_i.end_addr - ARITH_TEST_BACK; // RULE10
    end else begin
      push_ent.test_addr = do_i.end_addr; // RULE11 RULE15
    end
  end

  always_comb begin
    logic e2_end;
    logic e2_test;
    logic f1_end;
    logic late_now;
    logic e2_done;
    s_d = s_q;
    fetch_d.vld = 1'b1;
    fetch_d.addr = stage[ST_F1].addr + ADDR_STEP;
    flush_d = '0;
    push_d = 1'b0;
    pop_d = 1'b0;
    cnt_wr_d = 1'b0;
    cnt_d = top.count;
    e2_done = 1'b0;
    late_now = top.late | force_late_loop_test_bit_i; // RULE9
    e2_end = !empty && stage[ST_E2].vld && stage[ST_E2].addr == top.end_addr;
    e2_test = !empty && stage[ST_E2].vld && stage[ST_E2].addr == top.test_addr;
    f1_end = !empty && stage[ST_F1].vld && stage[ST_F1].addr == top.end_addr;
    s_d.exit_p = 1'b0;

    if (stage[ST_E2].vld && do_i.vld) begin
      push_d = 1'b1; // RULE1
    end

    unique case (s_q.st)
      HLT_ST_RUN: begin
        if (top.kind == HLT_KIND_COUNTER && late_now && e2_end) begin
          cnt_wr_d = 1'b1; // RULE6
          cnt_d = top.count - CNT_STEP;
          if (top.count == CNT_LAST) begin // RULE4
            pop_d = 1'b1; // RULE3
            flush_d = flush_upto(ST_M4); // RULE5
            fetch_d.vld = 1'b0; // RULE6
            s_d.exit_addr = top.end_addr + ADDR_STEP;
            s_d.st = HLT_ST_EXIT_WAIT;
            s_d.exit_p = 1'b1;
            e2_done = 1'b1;
          end
        end else if (top.kind == HLT_KIND_ARITH && e2_test && (cond_true_i || s_q.defer)) begin
          if (call_active_i && nested && !s_q.defer) begin
            s_d.defer = 1'b1; // RULE17
          end else begin
            pop_d = 1'b1; // RULE3
            flush_d = flush_upto(ST_M3); // RULE13 RULE16
            fetch_d.addr = top.end_addr; // RULE14
            s_d.defer = 1'b0;
            s_d.exit_p = 1'b1;
            e2_done = 1'b1;
          end
        end
        // false condition falls through with no flush
        if (!e2_done && f1_end) begin // RULE12
          if (top.kind == HLT_KIND_COUNTER && !late_now) begin
            cnt_wr_d = 1'b1;
            cnt_d = top.count - CNT_STEP;
            if (top.count == CNT_LAST) begin
              pop_d = 1'b1; // RULE3
              s_d.exit_p = 1'b1;
            end else begin
              fetch_d.addr = top.top_addr; // RULE2
            end
          end else begin
            fetch_d.addr = top.top_addr; // RULE2 RULE18
          end
        end
      end
      HLT_ST_EXIT_WAIT: begin
        fetch_d.addr = s_q.exit_addr; // RULE6
        s_d.st = HLT_ST_RUN;
      end
    endcase

    s_d.flush = flush_d; // RULE19
    s_d.push = push_d;
    s_d.pop = pop_d;
    // a new loop shows its own count as soon as it is pushed
    if (push_d) begin
      s_d.count = push_ent.count;
    end else begin
      s_d.count = cnt_wr_d ? cnt_d : top.count;
    end
    s_d.late = late_now;
    s_d.active = !empty;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= HLT_ST_RUN;
      s_q.exit_addr <= RESET_FETCH_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_addr_o = stage[ST_F1].addr;
  assign fetch_vld_o = stage[ST_F1].vld;
  assign flush_o = s_q.flush;
  assign stack_push_o = s_q.push;
  assign stack_pop_o = s_q.pop;
  assign loop_exit_o = s_q.exit_p;
  assign current_loop_count_o = s_q.count;
  assign loop_late_o = s_q.late;
  assign loop_active_o = s_q.active;

endmodule : hlt_loop_ctrl
`default_nettype wire

/* File: test/hlt_ctl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module hlt_ctl_sva import hlt_pkg::*; #(
  parameter int STAGES = NUM_STAGES,
  parameter int DEPTH = LOOP_STACK_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire hlt_do_t do_i,
  input wire logic cond_true_i,
  input wire logic call_active_i,
  input wire logic force_late_loop_test_bit_i,
  input wire hlt_addr_t fetch_addr_o,
  input wire logic fetch_vld_o,
  input wire logic [STAGES-1:0] flush_o,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic loop_exit_o,
  input wire hlt_cnt_t current_loop_count_o,
  input wire logic loop_late_o,
  input wire logic loop_active_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence s_refill;
    !fetch_vld_o ##1 fetch_vld_o;
  endsequence
  sequence s_step_on;
    fetch_vld_o ##1 (fetch_vld_o && fetch_addr_o == $past(fetch_addr_o) + ADDR_STEP);
  endsequence
  a_reset_fetch_one: assert property ($fell(rst_i) |-> !fetch_vld_o ##1
    (fetch_vld_o && fetch_addr_o == RESET_FETCH_ADDR + ADDR_STEP)) else $error("bad first fetch");
  a_exit_pops: assert property (loop_exit_o |-> stack_pop_o)
    else $error("exit without pop");
  a_late_refill: assert property (flush_o == 11'h3ff |-> loop_exit_o ##0 s_refill)
    else $error("late exit timing wrong");
  a_late_count_one: assert property (flush_o == 11'h3ff |-> $past(current_loop_count_o) == CNT_LAST)
    else $error("late exit at count not one");
  a_late_then_quiet: assert property (flush_o == 11'h3ff |=> flush_o == 11'h000)
    else $error("flush repeated");
  a_cond_keep_one: assert property (flush_o == 11'h1ff |-> loop_exit_o ##0 s_step_on)
    else $error("condition exit wrong");
  a_flush_shape: assert property (flush_o inside {11'h000, 11'h3ff, 11'h1ff})
    else $error("odd flush mask");
  a_push_active: assert property (stack_push_o |=> loop_active_o)
    else $error("push not active");
endmodule : hlt_ctl_sva
bind hlt_loop_ctrl hlt_ctl_sva #(.STAGES(STAGES), .DEPTH(DEPTH)) i_sva (.clk_sys_i, .rst_i, .do_i, .cond_true_i,
  .call_active_i, .force_late_loop_test_bit_i, .fetch_addr_o, .fetch_vld_o, .flush_o, .stack_push_o,
  .stack_pop_o, .loop_exit_o, .current_loop_count_o, .loop_late_o, .loop_active_o);
`default_nettype wire

/* File: test/hlt_pipe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hlt_pipe_model import hlt_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire hlt_addr_t fetch_addr_i,
  input wire logic fetch_vld_i,
  input wire logic [NUM_STAGES-1:0] flush_i,
  input wire hlt_addr_t start_addr_i,
  input wire hlt_do_t prog_i,
  output hlt_do_t do_o,
  output hlt_slot_t e2_o
);
  hlt_slot_t [NUM_STAGES-1:0] slot_q;
  hlt_slot_t [NUM_STAGES-1:0] view;
  // mirror of the slots, reported flushes applied
  always_comb begin
    view = slot_q;
    view[ST_F1] = '{vld: fetch_vld_i, addr: fetch_addr_i};
    // flush bit k-1 names the slot that has since moved into slot k
    for (int k = 1; k < NUM_STAGES; k++) begin
      view[k].vld = view[k].vld & ~flush_i[k-1];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      slot_q <= '0;
    end else begin
      slot_q <= {view[NUM_STAGES-2:0], view[ST_F1]};
    end
  end
  assign e2_o = view[ST_E2];
  always_comb begin
    do_o = '0;
    if (view[ST_E2].vld && view[ST_E2].addr == start_addr_i) begin
      do_o = prog_i;
      do_o.vld = 1'b1;
    end
  end
endmodule : hlt_pipe_model
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import hlt_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cond_true_i = 1'b0;
  logic call_active_i = 1'b0;
  logic force_late_loop_test_bit_i = 1'b0;
  hlt_do_t do_i;
  hlt_addr_t fetch_addr_o;
  logic fetch_vld_o;
  logic [NUM_STAGES-1:0] flush_o;
  logic stack_push_o;
  logic stack_pop_o;
  logic loop_exit_o;
  hlt_cnt_t current_loop_count_o;
  logic loop_late_o;
  logic loop_active_o;
  hlt_addr_t start_addr = 32'h00000004;
  hlt_do_t prog = '0;
  hlt_slot_t e2;
  logic [31:0] rng = 32'h0000000a;
  int errors = 0;
  int n_checks = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  hlt_loop_ctrl i_dut (.clk_sys_i, .rst_i, .do_i, .cond_true_i, .call_active_i, .force_late_loop_test_bit_i,
    .fetch_addr_o, .fetch_vld_o, .flush_o, .stack_push_o, .stack_pop_o, .loop_exit_o, .current_loop_count_o,
    .loop_late_o, .loop_active_o);
  hlt_pipe_model i_pipe (.clk_sys_i, .rst_i, .fetch_addr_i(fetch_addr_o), .fetch_vld_i(fetch_vld_o),
    .flush_i(flush_o), .start_addr_i(start_addr), .prog_i(prog), .do_o(do_i), .e2_o(e2));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic exp_late(input logic lop, input int len, input int cnt, input logic frc);
    return lop | (cnt != 0 && len * cnt < 11) | frc;
  endfunction : exp_late

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // one loop per run: reset, push, iterate, exit; a forever loop never exits
  task automatic run(input hlt_kind_t kind, input logic lop, input int len, input int cnt, input logic frc,
                     input int k);
    hlt_addr_t e;
    logic late;
    logic pend;
    logic nxt;
    logic [10:0] xf;
    int ex;
    int fl;
    int exits;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    cond_true_i <= 1'b0;
    force_late_loop_test_bit_i <= frc;
    start_addr = 32'h00000004 + rng[2:0];
    e = start_addr + 32'(len);
    late = exp_late(lop, len, cnt, frc) && kind == HLT_KIND_COUNTER;
    xf = kind == HLT_KIND_ARITH ? 11'h1ff : late ? 11'h3ff : 11'h000;
    prog <= '{vld: 1'b1, kind: kind, late_op: lop, end_addr: e, count: 32'(cnt)};
    {ex, fl, exits, pend, nxt} = '0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (60) begin
      @(posedge clk_sys_i);
      #1;
      if (stack_push_o === 1'b1) break;
    end
    if (stack_push_o !== 1'b1) begin
      errors++;
      finish_test();
    end
    if (kind == HLT_KIND_COUNTER) chk("pushed count", cnt, current_loop_count_o);
    for (int c = 0; c < 220; c++) begin
      @(posedge clk_sys_i);
      cond_true_i <= kind == HLT_KIND_FOREVER ? rng[0] : nxt;
      call_active_i <= rng[1];
      rng = xs(rng);
      #1;
      if (c == 0 && kind == HLT_KIND_COUNTER) chk("late select", late, loop_late_o);
      if (pend) chk("exit target", e + 32'h1, fetch_addr_o);
      pend = 1'b0;
      if (e2.vld === 1'b1 && e2.addr == e) ex++;
      nxt = nxt | (ex >= k && kind == HLT_KIND_ARITH);
      if (flush_o !== 11'h000) begin
        fl++;
        chk("flush slots", xf, flush_o);
      end
      if (loop_exit_o === 1'b1) begin
        exits++;
        chk("pop at exit", 1, stack_pop_o);
        if (kind == HLT_KIND_ARITH) chk("refetch end", e, fetch_addr_o);
        else if (late) chk("exit bubble", 0, fetch_vld_o);
        else chk("after end", e + 32'h1, fetch_addr_o);
        pend = late;
      end
    end
    chk("exits", kind != HLT_KIND_FOREVER, exits);
    chk("flush events", xf != 11'h000, fl);
    if (kind == HLT_KIND_FOREVER) chk("still looping", 1, loop_active_o);
    else chk("end executions", kind == HLT_KIND_ARITH ? k + 1 : cnt, ex);
  endtask : run

  initial begin
    run(HLT_KIND_COUNTER, 1'b1, 12, 2 + int'(rng[1:0]), 1'b0, 0);
    run(HLT_KIND_COUNTER, 1'b0, 12, 2 + int'(rng[1:0]), 1'b0, 0);
    run(HLT_KIND_COUNTER, 1'b0, 11, 1, 1'b0, 0);
    run(HLT_KIND_COUNTER, 1'b0, 10, 1, 1'b0, 0);
    run(HLT_KIND_COUNTER, 1'b0, 12, 3, 1'b1, 0);
    run(HLT_KIND_ARITH, 1'b0, 12, 0, 1'b0, 1 + int'(rng[1:0]));
    run(HLT_KIND_FOREVER, 1'b0, 11, 0, 1'b0, 0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
